// ### rtl/glk_top.sv
// guard lock state sequencing, indicator patterns and AXI4-Lite registers
module glk_top
  import glk_pkg::*;
#(
  parameter int unsigned P_FAST_HALF_CYC = FAST_HALF_CYC,
  parameter int unsigned P_ATTEMPT_CYC   = ATTEMPT_CYC,
  parameter int unsigned P_FAIL_CYC      = FAIL_CYC
) (
  input  wire logic              MCLK,
  input  wire logic              RESET,
  input  wire logic              ACT_PRESENT,
  input  wire logic              LOCK_CMD,
  input  wire logic              SAFE_IN_A,
  input  wire logic              SAFE_IN_B,
  input  wire logic              BOLT_EXT,
  input  wire logic              BOLT_RET,
  input  wire logic              SHORT_DET,
  input  wire logic              RFID_ERR,
  output logic                   LED_GREEN,
  output logic                   LED_RED,
  output logic                   BOLT_DRIVE,
  output logic                   SAFETY_OUTPUT_PAIR_A,
  output logic                   SAFETY_OUTPUT_PAIR_B,
  output logic                   IRQ,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);

  glk_pins_t       pins_raw;
  glk_pins_t       pins;
  logic            tick;
  logic [2:0]      step;
  glk_state_t      state_q;
  glk_state_t      state_d;
  glk_state_t      prev_q;
  logic            dir_lock_q;
  logic [31:0]     timer_q;
  logic [4:0]      boot_q;
  logic            ctrl_en_q;
  logic [EV_W-1:0] int_q;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] ev;
  glk_led_t        led_d;
  logic            lock;
  logic            inputs_ok;
  logic            want_ext;
  logic            aw_have_q;
  logic            w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0]     wdata_q;
  logic [3:0]      wstrb_q;
  logic            wr_fire;
  logic            wr_clr;
  logic [EV_W-1:0] clr_bits;

  assign pins_raw = {ACT_PRESENT, LOCK_CMD, SAFE_IN_A, SAFE_IN_B,
                     BOLT_EXT, BOLT_RET, SHORT_DET, RFID_ERR};

  glk_sync #(
    .W ($bits(glk_pins_t))
  ) u_sync (
    .clk (MCLK),
    .rst (RESET),
    .d   (pins_raw),
    .q   (pins)
  );

  glk_flash #(
    .HALF_CYC (P_FAST_HALF_CYC)
  ) u_flash (
    .clk  (MCLK),
    .rst  (RESET),
    .tick (tick),
    .step (step)
  );

  assign lock      = pins.lock_cmd & ctrl_en_q;
  assign inputs_ok = pins.safe_in_a & pins.safe_in_b;

  // faults are checked first so they override any normal transition
  always_comb
  begin
    state_d = state_q;
    if (state_q == ST_F_SHORT || state_q == ST_F_RFID)
      state_d = state_q;
    else if (pins.short_det)
      state_d = ST_F_SHORT;
    else if (pins.rfid_err)
      state_d = ST_F_RFID;
    else
    begin
      case (state_q)
        ST_BOOT:
          if (boot_q == BOOT_END_TICKS)
            state_d = ST_SAFE;
        ST_SAFE:
          if (lock)
            state_d = pins.act_present ? ST_LOCKING : ST_OPEN_LOCK;
        ST_OPEN_LOCK:
          if (!lock)
            state_d = ST_SAFE;
          else if (pins.act_present)
            state_d = ST_LOCKING;
        ST_LOCKING:
          if (!lock)
            state_d = ST_UNLOCKING;
          else if (!pins.act_present)
            state_d = ST_OPEN_LOCK;
          else if (pins.bolt_ext)
            state_d = inputs_ok ? ST_OPER : ST_WAIT_IN;
          else if (timer_q >= P_ATTEMPT_CYC)
            state_d = ST_STUCK;
        ST_WAIT_IN, ST_OPER:
          if (!pins.act_present)
            state_d = ST_F_RFID;
          else if (!pins.bolt_ext)
            state_d = ST_F_RFID;
          else if (!lock)
            state_d = ST_UNLOCKING;
          else
            state_d = inputs_ok ? ST_OPER : ST_WAIT_IN;
        ST_UNLOCKING:
          if (pins.bolt_ret)
            state_d = ST_SAFE;
          else if (timer_q >= P_ATTEMPT_CYC)
            state_d = ST_STUCK;
        ST_STUCK:
          if (timer_q >= P_FAIL_CYC)
            state_d = ST_F_RFID;
          else if (dir_lock_q && !lock)
            state_d = ST_UNLOCKING;
          else if (!dir_lock_q && lock)
            state_d = ST_LOCKING;
          else if (dir_lock_q && !pins.act_present)
            state_d = ST_OPEN_LOCK;
          else if (dir_lock_q && pins.bolt_ext)
            state_d = ST_WAIT_IN;
          else if (!dir_lock_q && pins.bolt_ret)
            state_d = ST_SAFE;
        default:
          state_d = ST_F_RFID;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      state_q <= ST_BOOT;
      prev_q  <= ST_BOOT;
    end
    else
    begin
      state_q <= state_d;
      prev_q  <= state_q;
    end
  end

  // direction of the attempt in progress, kept while stuck
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      dir_lock_q <= 1'b0;
    else if (state_d == ST_LOCKING)
      dir_lock_q <= 1'b1;
    else if (state_d == ST_UNLOCKING)
      dir_lock_q <= 1'b0;
  end

  // attempt timer keeps running into the stuck state to reach the fault
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      timer_q <= '0;
    else if (state_d != state_q && state_d != ST_STUCK)
      timer_q <= '0;
    else if (timer_q != 32'hFFFFFFFF)
      timer_q <= timer_q + 32'h1;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
      boot_q <= '0;
    else if (state_q == ST_BOOT && tick && boot_q != BOOT_END_TICKS)
      boot_q <= boot_q + 5'h1;
  end

  always_comb
  begin
    case (state_q)
      ST_LOCKING, ST_WAIT_IN, ST_OPER:
        want_ext = 1'b1;
      ST_STUCK:
        want_ext = dir_lock_q;
      default:
        want_ext = 1'b0;
    endcase
  end

  // flashes start in the on half so a pattern is visible at once after reset
  always_comb
  begin
    led_d = '0;
    case (state_q)
      ST_BOOT:
        led_d.green = (boot_q < BOOT_SLOW_TICKS) ? ~step[2]
                                                 : ~step[0];
      ST_SAFE, ST_UNLOCKING:
        led_d.red = 1'b1;
      ST_OPEN_LOCK:
        led_d.green = ~step[0];
      ST_LOCKING, ST_WAIT_IN:
        led_d.green = ~step[2];
      ST_OPER:
        led_d.green = 1'b1;
      ST_STUCK:
      begin
        led_d.green = PAT_GREEN[step];
        led_d.red   = PAT_RED[step];
      end
      ST_F_SHORT:
        led_d.red = ~step[2];
      ST_F_RFID:
        led_d.red = ~step[0];
      default:
        led_d.red = 1'b1;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      LED_GREEN            <= 1'b0;
      LED_RED              <= 1'b0;
      BOLT_DRIVE           <= 1'b0;
      SAFETY_OUTPUT_PAIR_A <= 1'b0;
      SAFETY_OUTPUT_PAIR_B <= 1'b0;
    end
    else
    begin
      LED_GREEN            <= led_d.green;
      LED_RED              <= led_d.red;
      BOLT_DRIVE           <= want_ext & pins.act_present;
      SAFETY_OUTPUT_PAIR_A <= state_q == ST_OPER;
      SAFETY_OUTPUT_PAIR_B <= state_q == ST_OPER;
    end
  end

  // one-cycle events on entry to each reported state
  always_comb
  begin
    ev           = '0;
    ev[EV_OPER]  = state_q == ST_OPER    && prev_q != ST_OPER;
    ev[EV_SAFE]  = state_q == ST_SAFE    && prev_q != ST_SAFE;
    ev[EV_STUCK] = state_q == ST_STUCK   && prev_q != ST_STUCK;
    ev[EV_SHORT] = state_q == ST_F_SHORT && prev_q != ST_F_SHORT;
    ev[EV_RFID]  = state_q == ST_F_RFID  && prev_q != ST_F_RFID;
  end

  assign wr_fire  = aw_have_q & w_have_q & ~S_AXI_BVALID;
  assign wr_clr   = wr_fire && waddr_q == A_INT_STAT && wstrb_q[0];
  assign clr_bits = wr_clr ? wdata_q[EV_W-1:0] : '0;

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      int_q <= '0;
    else
      int_q <= (int_q & ~clr_bits) | ev;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
      IRQ <= 1'b0;
    else
      IRQ <= |(int_q & mask_q);
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      ctrl_en_q <= CTRL_RST;
      mask_q    <= MASK_RST;
    end
    else if (wr_fire && wstrb_q[0])
    begin
      if (waddr_q == A_CTRL)
        ctrl_en_q <= wdata_q[0];
      if (waddr_q == A_INT_MASK)
        mask_q <= wdata_q[EV_W-1:0];
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      S_AXI_AWREADY <= 1'b0;
      aw_have_q     <= 1'b0;
      waddr_q       <= '0;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      S_AXI_AWREADY <= 1'b0;
      aw_have_q     <= 1'b1;
      waddr_q       <= S_AXI_AWADDR;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY)
      aw_have_q <= 1'b0;
    else if (!aw_have_q && !S_AXI_BVALID)
      S_AXI_AWREADY <= 1'b1;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      S_AXI_WREADY <= 1'b0;
      w_have_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      S_AXI_WREADY <= 1'b0;
      w_have_q     <= 1'b1;
      wdata_q      <= S_AXI_WDATA;
      wstrb_q      <= S_AXI_WSTRB;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY)
      w_have_q <= 1'b0;
    else if (!w_have_q && !S_AXI_BVALID)
      S_AXI_WREADY <= 1'b1;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (waddr_q[ADDR_W-1] || waddr_q[1:0] != 2'h0)
                      ? RESP_DECERR : RESP_OKAY;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= RESP_OKAY;
      S_AXI_RDATA   <= '0;
      case (S_AXI_ARADDR)
        A_CTRL:     S_AXI_RDATA[0] <= ctrl_en_q;
        A_STATUS:   S_AXI_RDATA[15:0] <= {pins, 4'h0, state_q};
        A_INT_STAT: S_AXI_RDATA[EV_W-1:0] <= int_q;
        A_INT_MASK: S_AXI_RDATA[EV_W-1:0] <= mask_q;
        default:    S_AXI_RRESP <= RESP_DECERR;
      endcase
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
    else if (!S_AXI_RVALID)
      S_AXI_ARREADY <= 1'b1;
  end

endmodule

// ### rtl/glk_pkg.sv
// constants, types and register map of the guard lock status indicator
// Notes on behaviour
// - solid green only when closed, locked, outputs on
// - solid red in safe unlocked state
// - closed door plus lock command starts locking
// - inputs not active: green 1 Hz, outputs off
// - lock command, no actuator: green 4 Hz
// - stuck lock/unlock: three green, one red
// - output short: latched red 1 Hz fault
// - RFID inconsistency: red 4 Hz fault
// - actuator lost while in use: red 4 Hz
// - bolt never reaches position: red 4 Hz fault
// - bolt never extends without actuator present
// - power-up: three slow, three fast green flashes
package glk_pkg;

  localparam int unsigned CLK_KHZ      = 250000;
  localparam int unsigned FAST_HALF_MS = 125;
  localparam int unsigned ATTEMPT_MS   = 300;
  localparam int unsigned FAIL_MS      = 2000;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;
  localparam int unsigned ATTEMPT_CYC   = ATTEMPT_MS * CLK_KHZ;
  localparam int unsigned FAIL_CYC      = FAIL_MS * CLK_KHZ;

  // fast ticks: 24 of slow flashing, then 6 of fast flashing
  localparam logic [4:0] BOOT_SLOW_TICKS = 5'h18;
  localparam logic [4:0] BOOT_END_TICKS  = 5'h1E;

  // eight fast half periods: green on steps 0, 2, 4 and red on step 6
  localparam logic [7:0] PAT_GREEN = 8'h15;
  localparam logic [7:0] PAT_RED   = 8'h40;

  localparam int          ADDR_W      = 5;
  localparam logic [4:0]  A_CTRL      = 5'h00;
  localparam logic [4:0]  A_STATUS    = 5'h04;
  localparam logic [4:0]  A_INT_STAT  = 5'h08;
  localparam logic [4:0]  A_INT_MASK  = 5'h0C;
  localparam logic        CTRL_RST    = 1'h1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  localparam int EV_W     = 5;
  localparam int EV_OPER  = 0;
  localparam int EV_SAFE  = 1;
  localparam int EV_STUCK = 2;
  localparam int EV_SHORT = 3;
  localparam int EV_RFID  = 4;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;

  typedef enum logic [3:0] {
    ST_BOOT, ST_SAFE, ST_OPEN_LOCK, ST_LOCKING, ST_WAIT_IN, ST_OPER,
    ST_UNLOCKING, ST_STUCK, ST_F_SHORT, ST_F_RFID
  } glk_state_t;

  typedef struct packed {
    logic act_present;
    logic lock_cmd;
    logic safe_in_a;
    logic safe_in_b;
    logic bolt_ext;
    logic bolt_ret;
    logic short_det;
    logic rfid_err;
  } glk_pins_t;

  typedef struct packed {
    logic green;
    logic red;
  } glk_led_t;

endpackage

// ### rtl/glk_sync.sv
// two-flop synchroniser for a group of pin inputs
module glk_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        meta_q[i] <= 1'b0;
        q[i]      <= 1'b0;
      end
      else
      begin
        meta_q[i] <= d[i];
        q[i]      <= meta_q[i];
      end
    end
  end

endmodule

// ### rtl/glk_flash.sv
// flash timebase: 4 Hz half-period tick and an eight step phase counter
module glk_flash
  import glk_pkg::*;
#(
  parameter int unsigned HALF_CYC = FAST_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  output logic            tick,
  output logic      [2:0] step
);

  logic [31:0] cnt_q;

  // step[0] gives 4 Hz and step[2] 1 Hz, both exactly 50% duty
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
      step  <= '0;
    end
    else if (cnt_q == HALF_CYC - 1)
    begin
      cnt_q <= '0;
      tick  <= 1'b1;
      step  <= step + 3'h1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule

// ### sim/glk_checker.sv
// concurrent checks on the guard lock indicator top-level ports
module glk_checker (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic ACT_PRESENT,
  input wire logic SAFE_IN_A,
  input wire logic SHORT_DET,
  input wire logic RFID_ERR,
  input wire logic LED_GREEN,
  input wire logic LED_RED,
  input wire logic BOLT_DRIVE,
  input wire logic SAFETY_OUTPUT_PAIR_A,
  input wire logic SAFETY_OUTPUT_PAIR_B,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID
);
  // flash figures assume the eight-cycle half period used in simulation
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  sequence s_short;
    SHORT_DET ##4 1;
  endsequence
  // skip the first red pulse, which may be cut short at fault entry
  sequence s_red_rise;
    RFID_ERR ##6 1 ##[20:30] $rose(LED_RED);
  endsequence

  a_pair_match: assert property (
    SAFETY_OUTPUT_PAIR_A == SAFETY_OUTPUT_PAIR_B)
    else $error("safety output halves differ");
  a_oper_green: assert property (
    SAFETY_OUTPUT_PAIR_A |-> LED_GREEN && !LED_RED)
    else $error("outputs on without solid green");
  a_inputs_off: assert property (
    !SAFE_IN_A [*5] |-> !SAFETY_OUTPUT_PAIR_A)
    else $error("outputs on with series input off");
  a_bolt_needs_act: assert property (
    !ACT_PRESENT [*5] |-> !BOLT_DRIVE)
    else $error("bolt driven with no actuator");
  a_leds_exclusive: assert property (
    !(LED_GREEN && LED_RED))
    else $error("both indicator colours lit");
  a_short_latch: assert property (
    s_short |-> (!LED_GREEN && !SAFETY_OUTPUT_PAIR_A) [*8])
    else $error("short fault not shown");
  a_rfid_rate: assert property (
    s_red_rise |-> LED_RED [*8] ##1 !LED_RED)
    else $error("red fast flash length wrong");
  a_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_write_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
endmodule

bind glk_top glk_checker u_glk_checker (
  .MCLK(MCLK), .RESET(RESET), .ACT_PRESENT(ACT_PRESENT),
  .SAFE_IN_A(SAFE_IN_A), .SHORT_DET(SHORT_DET), .RFID_ERR(RFID_ERR),
  .LED_GREEN(LED_GREEN), .LED_RED(LED_RED), .BOLT_DRIVE(BOLT_DRIVE),
  .SAFETY_OUTPUT_PAIR_A(SAFETY_OUTPUT_PAIR_A),
  .SAFETY_OUTPUT_PAIR_B(SAFETY_OUTPUT_PAIR_B),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID));

// ### sim/glk_lock_model.sv
// far side model: upstream series switch and the bolt mechanics
module glk_lock_model #(
  parameter int DLY = 4
) (
  input  wire logic clk,
  input  wire logic drive,
  input  wire logic jam,
  input  wire logic up_ok,
  output logic      ext,
  output logic      ret,
  output logic      safe_a,
  output logic      safe_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  logic       pos_q = 1'h0;

  // a jammed bolt never leaves its end stop
  always_ff @(posedge clk)
  begin
    if (jam || drive == pos_q)
      cnt_q <= 4'h0;
    else if (cnt_q == 4'(DLY))
    begin
      pos_q <= drive;
      cnt_q <= 4'h0;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end

  // mid-travel neither end stop sensor is made
  assign ext    = pos_q && cnt_q == 4'h0;
  assign ret    = !pos_q && cnt_q == 4'h0;
  assign safe_a = up_ok;
  assign safe_b = up_ok;
endmodule

// ### sim/testbench.sv
// self-checking bench for the guard lock status indicator
module testbench
  import glk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 8;
  typedef struct {
    logic [2:0] pin;
    glk_state_t st;
    logic       o;
    logic       b;
    int         fl;
  } glk_row_t;
  logic        mclk, reset, act, lock, ok, jam, shrt, rfe, pg, pr;
  logic        b_ext, b_ret, sa, sb, led_g, led_r, bolt, opa, opb, irq;
  logic        aw_v, w_v, bready, ar_v, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          n_fail, cmp_count, cyc, n, g, rr;
  // pins are {actuator, lock command, series inputs}
  glk_row_t rows [5] = '{
    '{3'h5, ST_SAFE, 1'h0, 1'h0, 0},
    '{3'h3, ST_OPEN_LOCK, 1'h0, 1'h0, T},
    '{3'h6, ST_WAIT_IN, 1'h0, 1'h1, 4*T},
    '{3'h7, ST_OPER, 1'h1, 1'h1, 0},
    '{3'h5, ST_SAFE, 1'h0, 1'h0, 0}};

  glk_top #(.P_FAST_HALF_CYC(T), .P_ATTEMPT_CYC(40), .P_FAIL_CYC(200))
  u_glk_top (
    .MCLK(mclk), .RESET(reset), .ACT_PRESENT(act), .LOCK_CMD(lock),
    .SAFE_IN_A(sa), .SAFE_IN_B(sb), .BOLT_EXT(b_ext), .BOLT_RET(b_ret),
    .SHORT_DET(shrt), .RFID_ERR(rfe), .LED_GREEN(led_g), .LED_RED(led_r),
    .BOLT_DRIVE(bolt), .SAFETY_OUTPUT_PAIR_A(opa),
    .SAFETY_OUTPUT_PAIR_B(opb), .IRQ(irq), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(ar_v),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  glk_lock_model u_glk_lock_model (.clk(mclk), .drive(bolt), .jam(jam),
    .up_ok(ok), .ext(b_ext), .ret(b_ret), .safe_a(sa), .safe_b(sb));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic axi_wr(logic [4:0] a, logic [31:0] v);
    aw_v <= 1'h1;
    w_v <= 1'h1;
    awaddr <= a;
    wdata <= v;
    bready <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (awready)
        aw_v <= 1'h0;
      if (wready)
        w_v <= 1'h0;
    end
    while ((aw_v && !awready) || (w_v && !wready));
    do @(posedge mclk); while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic axi_rd(logic [4:0] a);
    ar_v <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do @(posedge mclk); while (!arready);
    ar_v <= 1'h0;
    do @(posedge mclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic st_chk(glk_state_t s);
    axi_rd(A_STATUS);
    chk("state", d[3:0], s);
  endtask

  function automatic logic lv(logic red);
    return red ? led_r : led_g;
  endfunction

  // length of the next whole lit pulse, in cycles
  task automatic pulse(logic red);
    repeat (400) if (lv(red) !== 1'h0) @(posedge mclk);
    repeat (400) if (lv(red) !== 1'h1) @(posedge mclk);
    for (n = 0; lv(red) === 1'h1 && n < 400; n++) @(posedge mclk);
  endtask

  task automatic boot(int w);
    reset <= 1'h1;
    repeat (5) @(posedge mclk);
    reset <= 1'h0;
    repeat (w) @(posedge mclk);
  endtask

  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  initial
  begin
    {reset, act, lock, ok, jam, shrt, rfe} = 7'h40;
    {aw_v, w_v, bready, ar_v, rready} = 5'h00;
    {awaddr, araddr, wdata} = 42'h0;
    boot(0);
    for (int k = 0; k < 6; k++)
    begin
      pulse(1'h0);
      chk("boot flash", n, k < 3 ? 4 * T : T);
    end
    repeat (20) @(posedge mclk);
    chk("safe leds", {led_g, led_r}, 2'h1);
    axi_rd(A_CTRL);
    chk("ctrl reset", d[0], CTRL_RST);
    axi_rd(A_INT_MASK);
    chk("mask reset", d[EV_W-1:0], MASK_RST);
    axi_rd(A_INT_STAT);
    chk("safe event", d[EV_SAFE], 1'h1);
    chk("irq masked", irq, 1'h0);
    axi_wr(A_INT_MASK, 32'h1 << EV_SAFE);
    repeat (2) @(posedge mclk);
    chk("irq raised", irq, 1'h1);
    axi_wr(A_INT_STAT, 32'h1 << EV_SAFE);
    repeat (2) @(posedge mclk);
    chk("irq cleared", irq, 1'h0);
    axi_rd(5'h10);
    chk("read decerr", r, RESP_DECERR);
    axi_wr(5'h14, 32'h0);
    chk("write decerr", r, RESP_DECERR);
    $display("power-up and register tests done");
    foreach (rows[i])
    begin
      {act, lock, ok} <= rows[i].pin;
      repeat (30) @(posedge mclk);
      st_chk(rows[i].st);
      chk("outputs", {opa, opb}, {2{rows[i].o}});
      chk("bolt", bolt, rows[i].b);
      if (rows[i].fl == 0)
        chk("leds", {led_g, led_r}, {rows[i].o, !rows[i].o});
      else
      begin
        pulse(1'h0);
        chk("green flash", n, rows[i].fl);
      end
      $display("row %0d done", i);
    end
    chk("irq again", irq, 1'h1);
    jam <= 1'h1;
    {act, lock, ok} <= 3'h7;
    repeat (60) @(posedge mclk);
    st_chk(ST_STUCK);
    {g, rr} = 64'h0;
    repeat (64)
    begin
      pg = led_g;
      pr = led_r;
      @(posedge mclk);
      g += int'(led_g && !pg);
      rr += int'(led_r && !pr);
    end
    chk("stuck greens", g, 3);
    chk("stuck reds", rr, 1);
    repeat (200) @(posedge mclk);
    st_chk(ST_F_RFID);
    chk("fault drive", {bolt, opa}, 2'h0);
    jam <= 1'h0;
    $display("stuck test done");
    boot(300);
    chk("oper outputs", {opa, opb}, 2'h3);
    act <= 1'h0;
    repeat (20) @(posedge mclk);
    st_chk(ST_F_RFID);
    chk("lost drive", {bolt, opa, opb}, 3'h0);
    act <= 1'h1;
    boot(300);
    shrt <= 1'h1;
    repeat (10) @(posedge mclk);
    shrt <= 1'h0;
    repeat (30) @(posedge mclk);
    st_chk(ST_F_SHORT);
    chk("short drive", {bolt, opa, opb}, 3'h0);
    pulse(1'h1);
    chk("red slow", n, 4 * T);
    boot(300);
    rfe <= 1'h1;
    repeat (20) @(posedge mclk);
    st_chk(ST_F_RFID);
    pulse(1'h1);
    chk("red fast", n, T);
    rfe <= 1'h0;
    $display("fault tests done");
    report_and_stop;
  end
endmodule
